/* core/ctmc_top.sv */
// transceiver mode controller: sleep, wakeup, type select, frame pacing
`timescale 1ns/1ns
module ctmc_top #(
    parameter int MS_CYC = ctmc_pkg::MS_CYCLES,
    parameter int ZERO_MS = ctmc_pkg::ZERO_TIMEOUT_MS
) (
    input wire logic clk, // clock
    input wire logic rst, // sync reset, active high
    input wire ctmc_pkg::ctmc_bus_req_t bus, // register port request
    output logic [15:0] rdata, // read data, cycle after rd
    input wire logic all_tasks_started, // every task started
    input wire logic can_active, // controller communicating
    input wire logic tx_won_arb, // own frame past arbitration
    input wire logic tx_acked, // own frame acknowledged
    input wire logic bus_activity, // dominant edge seen on bus
    input wire logic rx_frame_end, // bus frame finished
    input wire logic tx_pending, // queue holds a frame
    input wire logic group_frame_req, // periodic group frame ready
    input wire logic buf_wait, // writer waits for buffer space
    output ctmc_pkg::ctmc_phy_t phy, // transceiver/controller controls
    output logic tx_release, // queue may send next frame
    output logic rx_store_enable, // received frames may be stored
    output logic group_frame_go, // send periodic group frame now
    output logic buf_timeout, // buffer wait timed out
    output logic cmd_error // last command rejected
);
    import ctmc_pkg::*;

    typedef enum logic [2:0] {
        ST_AWAKE = 3'b000,
        ST_SLEEP_PEND = 3'b001,
        ST_ASLEEP = 3'b010,
        ST_WAKE_FRAME = 3'b011
    } ctmc_state_t;

    ctmc_state_t state;
    ctmc_mode_t mode;
    ctmc_type_t xtype;
    logic dist_burst;
    logic switchable;
    logic [15:0] timeout_ms;
    logic [15:0] gap_cycles;
    logic [15:0] gap_cnt;
    logic tout_pulse;
    logic tout_seen;
    logic wr_mode, wr_type;
    ctmc_mode_t req_mode;
    ctmc_type_t req_type;
    logic mode_ok, type_ok;
    logic on_single_wire;

    function automatic logic mode_legal(input ctmc_mode_t m, input ctmc_type_t t);
        // single wire special modes exist only on single wire ports
        case (m)
            CTMC_MODE_NORMAL: mode_legal = 1'b1;
            CTMC_MODE_SLEEP: mode_legal = 1'b1;
            CTMC_MODE_SINGLE_WIRE_WAKEUP: mode_legal = (t == CTMC_TYPE_SINGLE_WIRE);
            CTMC_MODE_SINGLE_WIRE_HIGH_SPEED: mode_legal = (t == CTMC_TYPE_SINGLE_WIRE);
            default: mode_legal = 1'b0;
        endcase
    endfunction

    assign wr_mode = bus.wr && (bus.addr == ADDR_MODE);
    assign wr_type = bus.wr && (bus.addr == ADDR_TYPE);
    assign req_mode = ctmc_mode_t'(bus.wdata[2:0]);
    assign req_type = ctmc_type_t'(bus.wdata[2:0]);
    // a type switch may leave a single wire mode stored; gate its pin effects
    assign on_single_wire = (xtype == CTMC_TYPE_SINGLE_WIRE);

    always_comb begin
        mode_ok = mode_legal(req_mode, xtype);
        if (req_mode == CTMC_MODE_SLEEP) begin
            mode_ok = mode_ok && all_tasks_started && can_active;
        end
        // high speed cannot follow sleep directly
        if (req_mode == CTMC_MODE_SINGLE_WIRE_HIGH_SPEED && mode == CTMC_MODE_SLEEP) begin
            mode_ok = 1'b0;
        end
        type_ok = switchable && (bus.wdata[2:0] <= 3'b100);
    end

    // sleep state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_AWAKE;
        end else begin
            case (state)
                ST_AWAKE: begin
                    if (wr_mode && mode_ok && req_mode == CTMC_MODE_SLEEP) begin
                        // an arbitrated frame must finish first
                        state <= (tx_won_arb && !tx_acked) ? ST_SLEEP_PEND : ST_ASLEEP;
                    end
                end
                ST_SLEEP_PEND: begin
                    if (wr_mode && mode_ok && req_mode != CTMC_MODE_SLEEP) begin
                        state <= ST_AWAKE;
                    end else if (tx_acked) begin
                        state <= ST_ASLEEP;
                    end
                end
                ST_ASLEEP: begin
                    if (wr_mode && mode_ok && req_mode != CTMC_MODE_SLEEP) begin
                        state <= ST_AWAKE;
                    end else if (bus_activity) begin
                        state <= ST_WAKE_FRAME;
                    end
                end
                ST_WAKE_FRAME: begin
                    if (rx_frame_end) begin
                        state <= ST_AWAKE;
                    end
                end
                default: state <= ST_AWAKE;
            endcase
        end
    end

    // mode readback follows actual operation
    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= CTMC_MODE_NORMAL;
        end else if (state == ST_WAKE_FRAME && rx_frame_end) begin
            mode <= CTMC_MODE_NORMAL;
        end else if (wr_mode && mode_ok) begin
            mode <= req_mode;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            xtype <= CTMC_TYPE_HIGH_SPEED;
        end else if (wr_type && type_ok) begin
            // single interface-wide setting, so all tasks see it
            xtype <= req_type;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_error <= 1'b0;
        end else if (wr_mode) begin
            cmd_error <= !mode_ok;
        end else if (wr_type) begin
            cmd_error <= !type_ok;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dist_burst <= 1'b0;
            switchable <= 1'b1;
            timeout_ms <= TIMEOUT_RESET;
            gap_cycles <= GAP_RESET;
        end else if (bus.wr && bus.addr == ADDR_CONFIG) begin
            dist_burst <= bus.wdata[CFG_DIST_BIT];
            switchable <= bus.wdata[CFG_SWITCHABLE_BIT];
        end else if (bus.wr && bus.addr == ADDR_TIMEOUT) begin
            timeout_ms <= bus.wdata;
        end else if (bus.wr && bus.addr == ADDR_GAP) begin
            gap_cycles <= bus.wdata;
        end
    end

    // physical controls; a type switch changes the path and the single wire pin levels at the same edge,
    // with no pulse on the bus side
    always_ff @(posedge clk) begin
        if (rst) begin
            phy <= '{tx_enable: 1'b1, rx_enable: 1'b1, ack_enable: 1'b1,
                     wake_level: 1'b0, waveshape_off: 1'b0, connected: 1'b1,
                     xcvr: CTMC_TYPE_HIGH_SPEED};
        end else begin
            phy.tx_enable <= (state == ST_AWAKE || state == ST_SLEEP_PEND);
            phy.rx_enable <= (state == ST_AWAKE || state == ST_SLEEP_PEND);
            phy.ack_enable <= (state == ST_AWAKE || state == ST_SLEEP_PEND);
            phy.wake_level <= on_single_wire && mode == CTMC_MODE_SINGLE_WIRE_WAKEUP;
            phy.waveshape_off <= on_single_wire && mode == CTMC_MODE_SINGLE_WIRE_HIGH_SPEED;
            phy.connected <= (xtype != CTMC_TYPE_DISCONNECT);
            phy.xcvr <= xtype;
        end
    end

    // the queue itself keeps order; holding release freezes it at the sleep point
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_release <= 1'b0;
            rx_store_enable <= 1'b0;
        end else begin
            tx_release <= tx_pending && state == ST_AWAKE;
            rx_store_enable <= (state == ST_AWAKE || state == ST_SLEEP_PEND);
        end
    end

    // group pacing: uniform waits gap_cycles between frames, burst does not
    always_ff @(posedge clk) begin
        if (rst) begin
            gap_cnt <= 16'h0;
            group_frame_go <= 1'b0;
        end else begin
            group_frame_go <= 1'b0;
            if (gap_cnt != 16'h0) begin
                gap_cnt <= gap_cnt - 16'h1;
            end else if (group_frame_req && state == ST_AWAKE && !group_frame_go) begin
                group_frame_go <= 1'b1;
                gap_cnt <= dist_burst ? 16'h0 : gap_cycles;
            end
        end
    end

    ctmc_wait_timer #(
        .MS_CYC(MS_CYC),
        .ZERO_MS(ZERO_MS)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .waiting(buf_wait),
        .timeout_ms(timeout_ms),
        .expired(tout_pulse)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            buf_timeout <= 1'b0;
            tout_seen <= 1'b0;
        end else begin
            buf_timeout <= tout_pulse;
            if (tout_pulse) begin
                tout_seen <= 1'b1;
            end else if (bus.rd && bus.addr == ADDR_STATUS) begin
                tout_seen <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 16'h0;
        end else if (bus.rd) begin
            case (bus.addr)
                ADDR_MODE: rdata <= {13'h0, mode};
                ADDR_TYPE: rdata <= {13'h0, xtype};
                ADDR_CONFIG: rdata <= {14'h0, switchable, dist_burst};
                ADDR_TIMEOUT: rdata <= timeout_ms;
                ADDR_STATUS: rdata <= {12'h0, tout_seen, tx_pending,
                                       state == ST_ASLEEP, cmd_error};
                ADDR_GAP: rdata <= gap_cycles;
                default: rdata <= 16'h0;
            endcase
        end else begin
            rdata <= 16'h0;
        end
    end
endmodule

/* include/ctmc_pkg.sv */
// package for the can transceiver mode controller: constants, enums, carriers
package ctmc_pkg;
    localparam int CLK_MHZ = 250;
    localparam int MS_NS = 1000000;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int MS_CYCLES = MS_NS / CLK_NS;
    localparam int ZERO_TIMEOUT_MS = 10000;

    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_TYPE = 4'h1;
    localparam logic [3:0] ADDR_CONFIG = 4'h2;
    localparam logic [3:0] ADDR_TIMEOUT = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_GAP = 4'h5;

    localparam int CFG_DIST_BIT = 0;
    localparam int CFG_SWITCHABLE_BIT = 1;
    localparam int ST_ERR_BIT = 0;
    localparam int ST_SLEEP_BIT = 1;
    localparam int ST_PEND_BIT = 2;
    localparam int ST_TOUT_BIT = 3;

    localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
    localparam logic [15:0] GAP_RESET = 16'h0100;

    typedef enum logic [2:0] {
        CTMC_MODE_NORMAL = 3'b000,
        CTMC_MODE_SLEEP = 3'b001,
        CTMC_MODE_SINGLE_WIRE_WAKEUP = 3'b010,
        CTMC_MODE_SINGLE_WIRE_HIGH_SPEED = 3'b011
    } ctmc_mode_t;

    typedef enum logic [2:0] {
        CTMC_TYPE_HIGH_SPEED = 3'b000,
        CTMC_TYPE_LOW_SPEED_FT = 3'b001,
        CTMC_TYPE_SINGLE_WIRE = 3'b010,
        CTMC_TYPE_EXTERNAL = 3'b011,
        CTMC_TYPE_DISCONNECT = 3'b100
    } ctmc_type_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ctmc_bus_req_t;

    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic ack_enable;
        logic wake_level;
        logic waveshape_off;
        logic connected;
        ctmc_type_t xcvr;
    } ctmc_phy_t;
endpackage

/* core/ctmc_wait_timer.sv */
// buffer space wait timer with millisecond prescaler
`timescale 1ns/1ns
module ctmc_wait_timer #(
    parameter int MS_CYC = ctmc_pkg::MS_CYCLES,
    parameter int ZERO_MS = ctmc_pkg::ZERO_TIMEOUT_MS
) (
    input wire logic clk, // clock
    input wire logic rst, // sync reset
    input wire logic waiting, // writer waits for space
    input wire logic [15:0] timeout_ms, // configured limit
    output logic expired // one-cycle timeout pulse
);
    import ctmc_pkg::*;
    logic [31:0] pre;
    logic [15:0] ms;
    logic ms_tick;
    logic [15:0] limit;

    // zero stands for the long default wait
    assign limit = (timeout_ms == 16'h0000) ? 16'(ZERO_MS) : timeout_ms;
    assign ms_tick = waiting && (pre == 32'(MS_CYC - 1));

    always_ff @(posedge clk) begin
        if (rst || !waiting || ms_tick) begin
            pre <= 32'h0;
        end else begin
            pre <= pre + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        expired <= 1'b0;
        if (rst || !waiting) begin
            ms <= 16'h0;
        end else if (ms_tick) begin
            if (ms + 16'h1 >= limit) begin
                expired <= 1'b1;
                ms <= 16'h0;
            end else begin
                ms <= ms + 16'h1;
            end
        end
    end
endmodule

/* tb/ctmc_checker.sv */
// port-level assertions for the transceiver mode controller
`timescale 1ns/1ns
module ctmc_checker (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire ctmc_pkg::ctmc_bus_req_t bus, // register request
    input wire logic all_tasks_started, // tasks started
    input wire logic can_active, // communicating
    input wire logic tx_won_arb, // past arbitration
    input wire logic tx_acked, // acked
    input wire logic bus_activity, // bus edge
    input wire logic rx_frame_end, // frame end
    input wire logic buf_wait, // buffer wait
    input wire logic group_frame_req, // group ready
    input wire ctmc_pkg::ctmc_phy_t phy, // controls
    input wire logic group_frame_go, // group send
    input wire logic buf_timeout, // wait expired
    input wire logic cmd_error // rejected
);
    import ctmc_pkg::*;
    wire logic mode_wr = bus.wr && bus.addr == ADDR_MODE;
    wire logic [2:0] val = bus.wdata[2:0];
    wire logic asleep = !phy.tx_enable && !phy.rx_enable;
    wire logic may_sleep = all_tasks_started && can_active;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    a_sleep_refused: assert property (
        mode_wr && val == 3'h1 && !may_sleep |=> cmd_error) else $error("sleep not refused");
    a_sleep_silent: assert property (
        mode_wr && val == 3'h1 && may_sleep && !tx_won_arb ##1 !bus_activity |=> asleep)
        else $error("bus still enabled in sleep");
    a_arb_defers: assert property (
        tx_won_arb && !tx_acked && phy.tx_enable |=> phy.tx_enable)
        else $error("sleep cut a frame short");
    a_wake_no_ack: assert property (
        bus_activity && !phy.ack_enable |=> !phy.ack_enable) else $error("waking frame acked");
    a_frame_end_wake: assert property (
        rx_frame_end && asleep |=> ##1 phy.rx_enable && phy.tx_enable)
        else $error("no wake at frame end");
    a_sw_modes_only: assert property (
        phy.wake_level || phy.waveshape_off |-> phy.xcvr == CTMC_TYPE_SINGLE_WIRE)
        else $error("single wire mode on other type");
    a_no_hs_asleep: assert property (
        mode_wr && val == 3'h3 && asleep |=> cmd_error) else $error("high speed from sleep");
    a_type_refused: assert property (
        bus.wr && bus.addr == ADDR_TYPE && val > 3'h4 |=> cmd_error)
        else $error("bad type accepted");
    a_disconnect_detach: assert property (
        phy.connected == (phy.xcvr != CTMC_TYPE_DISCONNECT)) else $error("connect mismatch");
    a_group_spacing: assert property (
        group_frame_go |-> $past(group_frame_req) ##1 !group_frame_go)
        else $error("group frame spacing");
    a_wait_minimum: assert property (
        $rose(buf_wait) |-> !buf_timeout [*8]) else $error("early buffer timeout");
endmodule

bind ctmc_top ctmc_checker ctmc_checker_i (
    .clk, .rst, .bus, .all_tasks_started, .can_active, .tx_won_arb, .tx_acked,
    .bus_activity, .rx_frame_end, .buf_wait, .group_frame_req, .phy, .group_frame_go,
    .buf_timeout, .cmd_error);

/* tb/ctmc_bus_node.sv */
// remote bus node: waking frames, arbitration and ack of device frames
`timescale 1ns/1ns
module ctmc_bus_node (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire ctmc_pkg::ctmc_phy_t phy, // device controls
    input wire logic tx_release, // device may send
    input wire logic wake, // start waking frame
    input wire logic send, // device frame wanted
    input wire logic slow, // late ack
    output logic bus_activity, // frame start
    output logic rx_frame_end, // frame end
    output logic tx_won_arb, // device frame on bus
    output logic tx_acked // device frame acked
);
    logic [3:0] fcnt;
    logic [3:0] acnt;
    always_ff @(posedge clk) begin
        bus_activity <= 1'b0;
        rx_frame_end <= 1'b0;
        if (rst) begin
            fcnt <= 4'h0;
        end else if (wake) begin
            bus_activity <= 1'b1;
            fcnt <= 4'h4;
        end else if (fcnt != 4'h0) begin
            fcnt <= fcnt - 4'h1;
            rx_frame_end <= fcnt == 4'h1;
        end
    end
    // arbitration only while the device drives; slow ack stretches the frame
    always_ff @(posedge clk) begin
        tx_acked <= 1'b0;
        if (rst) begin
            tx_won_arb <= 1'b0;
            acnt <= 4'h0;
        end else if (tx_won_arb) begin
            acnt <= acnt + 4'h1;
            tx_acked <= acnt == (slow ? 4'h9 : 4'h2);
            tx_won_arb <= !tx_acked;
        end else if (send && tx_release && phy.tx_enable) begin
            tx_won_arb <= 1'b1;
            acnt <= 4'h0;
        end
    end
endmodule

/* tb/ctmc_top_tb.sv */
// self-checking bench for the transceiver mode controller
`timescale 1ns/1ns
module ctmc_top_tb;
    import ctmc_pkg::*;
    localparam int MSC = 10;
    localparam int ZMS = 3;
    typedef struct packed {
        logic w;
        logic [3:0] a;
        logic [15:0] d;
        logic e;
    } ctmc_row_t;
    // read rows: d is the expected data; write rows: e is the expected error
    ctmc_row_t rows [20] = '{
        {1'b0, 4'h0, 16'h0000, 1'b0}, {1'b0, 4'h1, 16'h0000, 1'b0},
        {1'b0, 4'h2, 16'h0002, 1'b0}, {1'b0, 4'h3, 16'h0000, 1'b0},
        {1'b0, 4'h4, 16'h0000, 1'b0}, {1'b0, 4'h5, 16'h0100, 1'b0},
        {1'b1, 4'hf, 16'habcd, 1'b0}, {1'b0, 4'hf, 16'h0000, 1'b0},
        {1'b1, 4'h0, 16'h0002, 1'b1}, {1'b1, 4'h1, 16'h0005, 1'b1},
        {1'b1, 4'h1, 16'h0004, 1'b0}, {1'b0, 4'h1, 16'h0004, 1'b0},
        {1'b1, 4'h1, 16'h0003, 1'b0}, {1'b1, 4'h1, 16'h0002, 1'b0},
        {1'b1, 4'h0, 16'h0003, 1'b0}, {1'b0, 4'h0, 16'h0003, 1'b0},
        {1'b1, 4'h0, 16'h0002, 1'b0}, {1'b1, 4'h0, 16'h0000, 1'b0},
        {1'b1, 4'h5, 16'h0004, 1'b0}, {1'b1, 4'h3, 16'h0001, 1'b0}};
    logic clk, rst, all_tasks_started, can_active, tx_won_arb, tx_acked, bus_activity;
    logic rx_frame_end, tx_pending, group_frame_req, buf_wait, tx_release, rx_store_enable;
    logic group_frame_go, buf_timeout, cmd_error, wake, send, slow;
    logic [15:0] rdata;
    ctmc_bus_req_t bus;
    ctmc_phy_t phy;
    int fails = 0;
    int check_count = 0;
    ctmc_top #(.MS_CYC(MSC), .ZERO_MS(ZMS)) ctmc_top_i (
        .clk, .rst, .bus, .rdata, .all_tasks_started, .can_active, .tx_won_arb, .tx_acked,
        .bus_activity, .rx_frame_end, .tx_pending, .group_frame_req, .buf_wait, .phy,
        .tx_release, .rx_store_enable, .group_frame_go, .buf_timeout, .cmd_error);
    ctmc_bus_node ctmc_bus_node_i (
        .clk, .rst, .phy, .tx_release, .wake, .send, .slow, .bus_activity, .rx_frame_end,
        .tx_won_arb, .tx_acked);
    always #2 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic pace(input logic [15:0] cfg, input logic [15:0] exp);
        int n;
        n = 0;
        wr(ADDR_CONFIG, cfg);
        group_frame_req <= 1'b1;
        repeat (12) begin
            @(posedge clk);
            #1 n += int'(group_frame_go);
        end
        group_frame_req <= 1'b0;
        cyc(8);
        chk(16'(n), exp);
    endtask
    task automatic tmo(input logic [15:0] ms, input logic [15:0] exp);
        logic [15:0] n;
        n = 16'h0;
        wr(ADDR_TIMEOUT, ms);
        buf_wait <= 1'b1;
        repeat (60) begin
            @(posedge clk);
            n += 16'h1;
            #1 if (buf_timeout === 1'b1) break;
        end
        buf_wait <= 1'b0;
        chk(n, exp);
        cyc(2);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        final_report();
    end
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        bus = '0;
        {all_tasks_started, can_active, tx_pending, group_frame_req, buf_wait} = 5'b11000;
        {wake, send, slow} = 3'b000;
        cyc(8);
        rst <= 1'b0;
        cyc(1);
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
                #1 chk(16'(cmd_error), 16'(rows[i].e));
            end else begin
                rd(rows[i].a, rows[i].d);
            end
        end
        $display("register table done");
        tx_pending <= 1'b1;
        all_tasks_started <= 1'b0;
        wr(ADDR_MODE, 16'h0001);
        #1 chk(16'(cmd_error), 16'h0001);
        all_tasks_started <= 1'b1;
        wr(ADDR_MODE, 16'h0001);
        cyc(2);
        #1 chk(16'({phy.tx_enable, phy.rx_enable, tx_release}), 16'h0000);
        rd(ADDR_STATUS, 16'h0006);
        wr(ADDR_MODE, 16'h0003);
        #1 chk(16'(cmd_error), 16'h0001);
        $display("sleep entry done");
        wake <= 1'b1;
        cyc(1);
        wake <= 1'b0;
        cyc(3);
        #1 chk(16'({phy.ack_enable, rx_store_enable}), 16'h0000);
        cyc(5);
        rd(ADDR_MODE, 16'h0000);
        chk(16'({phy.rx_enable, phy.tx_enable, tx_release}), 16'h0007);
        $display("remote wakeup done");
        slow <= 1'b1;
        send <= 1'b1;
        repeat (20) if (tx_won_arb !== 1'b1) @(posedge clk);
        send <= 1'b0;
        wr(ADDR_MODE, 16'h0001);
        cyc(3);
        #1 chk(16'(phy.tx_enable), 16'h0001);
        cyc(10);
        #1 chk(16'(phy.tx_enable), 16'h0000);
        wr(ADDR_MODE, 16'h0000);
        cyc(1);
        #1 chk(16'({phy.tx_enable, phy.rx_enable, phy.ack_enable}), 16'h0007);
        $display("deferred sleep done");
        wr(ADDR_MODE, 16'h0002);
        cyc(1);
        #1 chk(16'({phy.wake_level, phy.tx_enable}), 16'h0003);
        wr(ADDR_MODE, 16'h0003);
        cyc(1);
        #1 chk(16'({phy.waveshape_off, phy.wake_level, phy.tx_enable}), 16'h0005);
        wr(ADDR_MODE, 16'h0000);
        cyc(1);
        $display("single wire modes done");
        pace(16'h0002, 16'h0003);
        pace(16'h0003, 16'h0006);
        wr(ADDR_TYPE, 16'h0004);
        cyc(1);
        #1 chk(16'({phy.connected, phy.xcvr}), 16'h0004);
        wr(ADDR_TYPE, 16'h0003);
        cyc(1);
        #1 chk(16'({phy.connected, phy.xcvr}), 16'h000b);
        wr(ADDR_TYPE, 16'h0002);
        cyc(1);
        wr(ADDR_CONFIG, 16'h0001);
        cyc(1);
        wr(ADDR_TYPE, 16'h0001);
        #1 chk(16'(cmd_error), 16'h0001);
        rd(ADDR_TYPE, 16'h0002);
        tmo(16'h0001, 16'(MSC + 1));
        tmo(16'h0000, 16'(ZMS * MSC + 1));
        rd(ADDR_STATUS, 16'h000d);
        rd(ADDR_STATUS, 16'h0005);
        $display("pacing and timeout done");
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        rd(ADDR_TYPE, 16'h0000);
        rd(ADDR_GAP, 16'h0100);
        $display("second reset done");
        final_report();
    end
endmodule
